// [include/wdru_pkg.sv]
package wdru_pkg;
    // system clock
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_PERIOD_NS = 8;
    // low-speed internal oscillator, emulated as an enable tick
    localparam int WDT_CLK_HZ = 32_000;
    localparam int OSC_DIV = CLK_HZ / WDT_CLK_HZ;
    localparam int OSC_DIV_W = 12;
    // key fault reset delay, a least time so it rounds up
    localparam int KEY_DELAY_NS = 1_000;
    localparam int KEY_DELAY_CYC = (KEY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int KEY_DELAY_W = 16;
    // watchdog counter
    localparam int CNT_W = 18;
    localparam int SEL_W = 3;
    localparam int TAP_BITS [0:7] = '{8, 10, 12, 14, 15, 16, 17, 18};
    // apb map
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_FLAGS = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    // watchdog_control layout
    localparam int CTRL_W = 8;
    localparam int KEY_LSB = 3;
    localparam int KEY_MSB = 7;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;
    localparam logic [4:0] KEY_ENABLE = 5'h0a;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [7:0] CONTROL_POR = 8'h53;
    // reset_cause_flags layout
    localparam int FLAG_KEY_FAULT = 0;
    // status layout
    localparam int STS_TIMEOUT = 0;
    localparam int STS_POWER_DOWN = 1;
    localparam int STS_RUNNING = 2;
    localparam int STS_KEY_PENDING = 3;
endpackage

// [include/wdru_wdt_if.sv]
`timescale 1ns/100ps
interface wdru_wdt_if;
    logic ce;
    logic tick;
    logic clear;
    logic enable;
    logic [wdru_pkg::SEL_W-1:0] sel;
    logic timeout;
    modport ctl (output ce, output clear, output enable, output sel, input tick, input timeout);
    modport osc (input ce, output tick);
    modport cnt (input ce, input tick, input clear, input enable, input sel, output timeout);
endinterface

// [hw/wdru_osc_tick.sv]
`timescale 1ns/100ps
module wdru_osc_tick #(
    parameter int DIV = wdru_pkg::OSC_DIV
)(
    input wire logic clk,
    input wire logic rst_b,
    wdru_wdt_if.osc wd
);
    logic [wdru_pkg::OSC_DIV_W-1:0] div_ff;
    logic tick_ff;

    // free-running divider; runs regardless of the key so the tick phase never drifts
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end
        else if (wd.ce)
        begin
            if (div_ff == wdru_pkg::OSC_DIV_W'(DIV - 1))
            begin
                div_ff <= '0;
                tick_ff <= 1'b1;
            end
            else
            begin
                div_ff <= div_ff + 1'b1;
                tick_ff <= 1'b0;
            end
        end
    end

    assign wd.tick = tick_ff;
endmodule

// [hw/wdru_counter.sv]
`timescale 1ns/100ps
module wdru_counter #(
    parameter int CNT_W = wdru_pkg::CNT_W
)(
    input wire logic clk,
    input wire logic rst_b,
    wdru_wdt_if.cnt wd
);
    logic [CNT_W-1:0] count_ff;
    logic timeout_ff;
    logic [CNT_W-1:0] tap_mask;
    logic carry;

    // low bits covered by the selected tap; carry when they are all ones
    always_comb
    begin
        tap_mask = ~({CNT_W{1'b1}} << wdru_pkg::TAP_BITS[wd.sel]);
        carry = &(count_ff | ~tap_mask);
    end

    // clear wins over counting so a restart never loses to a tick
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_ff <= '0;
        else if (wd.ce)
        begin
            if (wd.clear)
                count_ff <= '0;
            else if (wd.enable && wd.tick)
                count_ff <= count_ff + 1'b1;
        end
    end

    // one-cycle time-out pulse on the carry out of the selected tap
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            timeout_ff <= 1'b0;
        else if (wd.ce)
            timeout_ff <= !wd.clear && wd.enable && wd.tick && carry;
    end

    assign wd.timeout = timeout_ff;
endmodule

// [hw/wdru_top.sv]
// How it works
// - counter advances on a ~32 kHz tick divided down from the system clock
// - key field 01010 enables the watchdog and lets it count
// - key field 10101 disables the watchdog
// - any other key value gives a full device reset after a fixed delay
// - an invalid-key reset sets bit 0 of reset_cause_flags
// - that flag is sticky, zero at power-on, cleared only by writing zero
// - period select picks 2^8,10,12,14,15,16,17,18 watchdog clock periods
// - at power-on the key is the enable code and period select is 011
// - time-out in normal running resets the device and sets the time-out flag
// - time-out in sleep or idle sets the flag and clears only PC and SP
// - count cleared by key fault, clear instruction, halt, or reset pin low
// - bits 7 to 3 of reset_cause_flags read as zero
// - power-on reset forces the program counter to zero
// - power-on sets all port data and direction bits high, pins as inputs
// - halt clears the count, sets power-down flag, clears time-out flag
`timescale 1ns/100ps
module wdru_top #(
    parameter int KEY_DELAY = wdru_pkg::KEY_DELAY_CYC,
    // system clocks per watchdog clock period; follows the system clock rate
    parameter int TICK_DIV = wdru_pkg::OSC_DIV
)(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [wdru_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CLEAR_WATCHDOG_INSTR,
    input wire logic HALT_INSTR,
    input wire logic SLEEP_IDLE,
    input wire logic EXTERNAL_RESET_PIN_B,
    output logic DEVICE_RESET,
    output logic PC_SP_CLEAR,
    output logic PC_FORCE_ZERO,
    output logic PORT_INPUT_INIT,
    output logic TIMEOUT_STATUS_FLAG,
    output logic POWER_DOWN_FLAG
);
    wdru_wdt_if wd ();

    logic [wdru_pkg::CTRL_W-1:0] ctrl_ff;
    logic key_fault_reset_flag_ff;
    logic timeout_status_flag_ff;
    logic power_down_flag_ff;
    logic key_pending_ff;
    logic [wdru_pkg::KEY_DELAY_W-1:0] key_cnt_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic device_reset_ff;
    logic pc_sp_clear_ff;
    logic pc_force_zero_ff;
    logic port_input_init_ff;

    logic [4:0] key;
    logic key_valid;
    logic key_fire;
    logic wd_timeout;
    logic full_reset;
    logic apb_access;
    logic apb_done;
    logic wr_ctrl;
    logic wr_flags;
    logic mapped;
    logic [31:0] nxt_prdata;

    // key decode
    always_comb
    begin
        key = ctrl_ff[wdru_pkg::KEY_MSB:wdru_pkg::KEY_LSB];
        key_valid = (key == wdru_pkg::KEY_ENABLE) || (key == wdru_pkg::KEY_DISABLE);
        key_fire = key_pending_ff && (key_cnt_ff == wdru_pkg::KEY_DELAY_W'(KEY_DELAY - 1));
        wd_timeout = wd.timeout;
        full_reset = key_fire || (wd_timeout && !SLEEP_IDLE);
    end

    // apb phases; writes land on the completing edge only
    always_comb
    begin
        apb_access = PSEL && PENABLE && !pready_ff;
        apb_done = PSEL && PENABLE && pready_ff;
        wr_ctrl = apb_done && PWRITE && (PADDR == wdru_pkg::OFS_CONTROL);
        wr_flags = apb_done && PWRITE && (PADDR == wdru_pkg::OFS_FLAGS);
        mapped = (PADDR == wdru_pkg::OFS_CONTROL) || (PADDR == wdru_pkg::OFS_FLAGS)
            || (PADDR == wdru_pkg::OFS_STATUS);
    end

    // read mux; status is read-only, writes to it are dropped silently
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        case (PADDR)
            wdru_pkg::OFS_CONTROL:
                nxt_prdata[wdru_pkg::CTRL_W-1:0] = ctrl_ff;
            wdru_pkg::OFS_FLAGS:
                nxt_prdata[wdru_pkg::FLAG_KEY_FAULT] = key_fault_reset_flag_ff;
            wdru_pkg::OFS_STATUS:
            begin
                nxt_prdata[wdru_pkg::STS_TIMEOUT] = timeout_status_flag_ff;
                nxt_prdata[wdru_pkg::STS_POWER_DOWN] = power_down_flag_ff;
                nxt_prdata[wdru_pkg::STS_RUNNING] = wd.enable;
                nxt_prdata[wdru_pkg::STS_KEY_PENDING] = key_pending_ff;
            end
            default:
                nxt_prdata = 32'h0000_0000;
        endcase
    end

    // apb slave: one wait state, pready and read data from flops
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else if (CE)
        begin
            if (apb_access)
            begin
                pready_ff <= 1'b1;
                pslverr_ff <= !mapped;
                prdata_ff <= PWRITE ? 32'h0000_0000 : nxt_prdata;
            end
            else
            begin
                pready_ff <= 1'b0;
                pslverr_ff <= 1'b0;
            end
        end
    end

    // control register; a full reset restores power-on contents over any write
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            ctrl_ff <= wdru_pkg::CONTROL_POR;
        else if (CE)
        begin
            if (full_reset)
                ctrl_ff <= wdru_pkg::CONTROL_POR;
            else if (wr_ctrl)
                ctrl_ff <= PWDATA[wdru_pkg::CTRL_W-1:0];
        end
    end

    // invalid key delay; fixing the key before expiry cancels the reset
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            key_pending_ff <= 1'b0;
            key_cnt_ff <= '0;
        end
        else if (CE)
        begin
            if (key_valid || key_fire)
            begin
                key_pending_ff <= 1'b0;
                key_cnt_ff <= '0;
            end
            else if (!key_pending_ff)
                key_pending_ff <= 1'b1;
            else
                key_cnt_ff <= key_cnt_ff + 1'b1;
        end
    end

    // key fault flag; the hardware set wins over a software clear
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            key_fault_reset_flag_ff <= 1'b0;
        else if (CE)
        begin
            if (key_fire)
                key_fault_reset_flag_ff <= 1'b1;
            else if (wr_flags && !PWDATA[wdru_pkg::FLAG_KEY_FAULT])
                key_fault_reset_flag_ff <= 1'b0;
        end
    end

    // time-out flag; a time-out in the halt cycle keeps it set
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            timeout_status_flag_ff <= 1'b0;
        else if (CE)
        begin
            if (wd_timeout)
                timeout_status_flag_ff <= 1'b1;
            else if (HALT_INSTR)
                timeout_status_flag_ff <= 1'b0;
        end
    end

    // power-down flag: halt sets, clear instruction clears
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            power_down_flag_ff <= 1'b0;
        else if (CE)
        begin
            if (HALT_INSTR)
                power_down_flag_ff <= 1'b1;
            else if (CLEAR_WATCHDOG_INSTR)
                power_down_flag_ff <= 1'b0;
        end
    end

    // reset strobes towards the core
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            device_reset_ff <= 1'b0;
            pc_sp_clear_ff <= 1'b0;
        end
        else if (CE)
        begin
            device_reset_ff <= full_reset;
            pc_sp_clear_ff <= wd_timeout && SLEEP_IDLE && !key_fire;
        end
    end

    // power-on strobes, high from reset until the first enabled edge
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pc_force_zero_ff <= 1'b1;
            port_input_init_ff <= 1'b1;
        end
        else if (CE)
        begin
            pc_force_zero_ff <= full_reset;
            port_input_init_ff <= 1'b0;
        end
    end

    // counter controls
    always_comb
    begin
        wd.ce = CE;
        // count clear; a time-out also restarts the count
        wd.clear = key_fire || CLEAR_WATCHDOG_INSTR || HALT_INSTR || !EXTERNAL_RESET_PIN_B || wd_timeout;
        // run only on the enable code
        wd.enable = (key == wdru_pkg::KEY_ENABLE);
        wd.sel = ctrl_ff[wdru_pkg::SEL_MSB:wdru_pkg::SEL_LSB];
    end

    wdru_osc_tick #(
        .DIV(TICK_DIV)
    ) u_osc (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .wd(wd.osc)
    );

    wdru_counter #(
        .CNT_W(wdru_pkg::CNT_W)
    ) u_cnt (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .wd(wd.cnt)
    );

    // outputs straight from flops
    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign DEVICE_RESET = device_reset_ff;
    assign PC_SP_CLEAR = pc_sp_clear_ff;
    assign PC_FORCE_ZERO = pc_force_zero_ff;
    assign PORT_INPUT_INIT = port_input_init_ff;
    assign TIMEOUT_STATUS_FLAG = timeout_status_flag_ff;
    assign POWER_DOWN_FLAG = power_down_flag_ff;
endmodule

// [verif/wdru_top_sva.sv]
`timescale 1ns/100ps
module wdru_top_sva #(
    parameter int KEY_DELAY = 4
)(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CLEAR_WATCHDOG_INSTR,
    input wire logic HALT_INSTR,
    input wire logic DEVICE_RESET,
    input wire logic PC_SP_CLEAR,
    input wire logic PC_FORCE_ZERO,
    input wire logic PORT_INPUT_INIT,
    input wire logic TIMEOUT_STATUS_FLAG,
    input wire logic POWER_DOWN_FLAG
);
    // slack covers the pending stage and the pulse stage
    localparam int KD_MAX = KEY_DELAY + 4;
    // one clock domain, quiet while in reset
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // completed write of a key that is neither enable nor disable
    sequence s_bad_key;
        PSEL && PENABLE && PREADY && PWRITE && CE && PADDR == 12'h000
            && PWDATA[7:3] != wdru_pkg::KEY_ENABLE && PWDATA[7:3] != wdru_pkg::KEY_DISABLE;
    endsequence
    // halt taken and no time-out landing in the same step
    sequence s_halt_quiet;
        HALT_INSTR && CE ##1 !PC_SP_CLEAR && !DEVICE_RESET;
    endsequence
    // a rewrite of the control register may cancel the pending reset
    a_bad_key_reset: assert property (s_bad_key |-> ##[1:KD_MAX] (DEVICE_RESET || (PSEL && PWRITE && PADDR == 12'h000)))
        else $error("bad key gave no device reset");
    a_reset_pulse: assert property (DEVICE_RESET |=> !DEVICE_RESET)
        else $error("device reset longer than one cycle");
    a_to_cause: assert property ($rose(TIMEOUT_STATUS_FLAG) |-> DEVICE_RESET || PC_SP_CLEAR)
        else $error("time-out flag set without a time-out action");
    a_sleep_only: assert property (PC_SP_CLEAR |-> !DEVICE_RESET && TIMEOUT_STATUS_FLAG)
        else $error("sleep time-out action wrong");
    a_to_sticky: assert property (TIMEOUT_STATUS_FLAG && !(HALT_INSTR && CE) |=> TIMEOUT_STATUS_FLAG)
        else $error("time-out flag dropped");
    a_halt_pd: assert property (HALT_INSTR && CE |=> POWER_DOWN_FLAG)
        else $error("halt did not set power-down flag");
    a_halt_to: assert property (s_halt_quiet |-> !TIMEOUT_STATUS_FLAG)
        else $error("halt did not clear time-out flag");
    a_clr_pd: assert property (CLEAR_WATCHDOG_INSTR && !HALT_INSTR && CE |=> !POWER_DOWN_FLAG)
        else $error("clear instruction left power-down flag");
    a_pc_zero: assert property (DEVICE_RESET |-> PC_FORCE_ZERO)
        else $error("device reset without program counter zero");
    a_port_init: assert property (!PORT_INPUT_INIT |=> !PORT_INPUT_INIT)
        else $error("port init rose outside reset");
    a_apb_err: assert property (PREADY |-> PSLVERR == !(PADDR inside {12'h000, 12'h004, 12'h008}))
        else $error("error response on wrong address");
endmodule
bind wdru_top wdru_top_sva #(.KEY_DELAY(KEY_DELAY)) u_sva (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CLEAR_WATCHDOG_INSTR(CLEAR_WATCHDOG_INSTR), .HALT_INSTR(HALT_INSTR), .DEVICE_RESET(DEVICE_RESET),
    .PC_SP_CLEAR(PC_SP_CLEAR), .PC_FORCE_ZERO(PC_FORCE_ZERO), .PORT_INPUT_INIT(PORT_INPUT_INIT),
    .TIMEOUT_STATUS_FLAG(TIMEOUT_STATUS_FLAG), .POWER_DOWN_FLAG(POWER_DOWN_FLAG)
);

// [verif/wdru_top_test.sv]
`timescale 1ns/100ps
module wdru_top_test;
    localparam int KD = 4;
    // short watchdog clock period so that time-outs fit in the run
    localparam int TD = 4;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic clr = 1'b0;
    logic halt = 1'b0;
    logic sleep = 1'b0;
    logic pin_b = 1'b1;
    logic ce = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, dev_rst, pcsp, pcz, pinit, to_flag, pd_flag;
    int error_cnt = 0;
    int checks_done = 0;
    int rst_seen = 0;
    int rst_base = 0;
    int cyc = 0;
    // rows: [31] write, [27:16] address, [15:8] write data, [7:0] read data
    logic [31:0] rows [0:13] = '{32'h00000053, 32'h00040000, 32'h00080004, 32'h8000a800, 32'h00080000,
        32'h8008ff00, 32'h00080000, 32'h80005300, 32'h00080004, 32'h000c0000, 32'h800cff00, 32'h00000053,
        32'h80040100, 32'h00040000};

    wdru_top #(.KEY_DELAY(KD), .TICK_DIV(TD)) dut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CLEAR_WATCHDOG_INSTR(clr), .HALT_INSTR(halt), .SLEEP_IDLE(sleep), .EXTERNAL_RESET_PIN_B(pin_b),
        .DEVICE_RESET(dev_rst), .PC_SP_CLEAR(pcsp), .PC_FORCE_ZERO(pcz), .PORT_INPUT_INIT(pinit),
        .TIMEOUT_STATUS_FLAG(to_flag), .POWER_DOWN_FLAG(pd_flag)
    );

    // 125 MHz system clock
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    // count device reset pulses, they last a single cycle
    always @(posedge clk_sys)
        if (dev_rst === 1'b1)
            rst_seen++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; waits for pready, only the watchdog ends a dead wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] x);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1);
        check(pslverr, a > 12'h008);
        if (!wr)
            check(prdata, {24'h0, x});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // the whole run is about five thousand three hundred cycles, mostly the two time-outs
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clk_sys);
        check(pcz, 1'b1);
        check(pinit, 1'b1);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check(pinit, 1'b0);
        for (int i = 0; i < 14; i++)
            apb(rows[i][31], rows[i][27:16], rows[i][15:8], rows[i][7:0]);
        // every period code must read back as written
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 12'h000, {5'h0a, i[2:0]}, 8'h00);
            apb(1'b0, 12'h000, 8'h00, {5'h0a, i[2:0]});
        end
        // normal time-out, period 2^8: the pin holds the count at zero while sel 000 is written
        pin_b <= 1'b0;
        apb(1'b1, 12'h000, 8'h50, 8'h00);
        pin_b <= 1'b1;
        cyc = 0;
        while (dev_rst !== 1'b1 && cyc < 512 * TD)
        begin
            @(posedge clk_sys);
            cyc++;
        end
        check(cyc >= 255 * TD + 3 && cyc <= 256 * TD + 2, 1'b1);
        check(to_flag, 1'b1);
        apb(1'b0, 12'h000, 8'h00, 8'h53);
        // period 2^10 for the sleep time-out below
        apb(1'b1, 12'h000, 8'h51, 8'h00);
        // halt in sleep, then clear instruction with the reset pin low
        sleep <= 1'b1;
        halt <= 1'b1;
        @(posedge clk_sys);
        halt <= 1'b0;
        @(posedge clk_sys);
        check(pd_flag, 1'b1);
        check(to_flag, 1'b0);
        // clear instruction drops the power-down flag; the low pin holds the count at zero
        clr <= 1'b1;
        pin_b <= 1'b0;
        @(posedge clk_sys);
        clr <= 1'b0;
        @(posedge clk_sys);
        check(pd_flag, 1'b0);
        // sleep time-out, period 2^10 counted from the pin release
        pin_b <= 1'b1;
        rst_base = rst_seen;
        cyc = 0;
        while (pcsp !== 1'b1 && cyc < 2048 * TD)
        begin
            @(posedge clk_sys);
            cyc++;
        end
        check(cyc >= 1023 * TD + 3 && cyc <= 1024 * TD + 2, 1'b1);
        check(to_flag, 1'b1);
        check(rst_seen, rst_base);
        apb(1'b0, 12'h000, 8'h00, 8'h51);
        sleep <= 1'b0;
        // corrupt key: pending seen in status, delayed reset, sticky flag, control restored
        rst_base = rst_seen;
        apb(1'b1, 12'h000, 8'hf8, 8'h00);
        apb(1'b0, 12'h008, 8'h00, 8'h09);
        for (int n = 0; n < 40 && rst_seen == rst_base; n++)
            @(posedge clk_sys);
        check(rst_seen, rst_base + 1);
        apb(1'b0, 12'h004, 8'h00, 8'h01);
        apb(1'b0, 12'h000, 8'h00, 8'h53);
        apb(1'b1, 12'h004, 8'h00, 8'h00);
        apb(1'b0, 12'h004, 8'h00, 8'h00);
        // a halt on a frozen edge must not reach the power-down flag
        ce <= 1'b0;
        halt <= 1'b1;
        @(posedge clk_sys);
        halt <= 1'b0;
        ce <= 1'b1;
        @(posedge clk_sys);
        check(pd_flag, 1'b0);
        // second reset in mid-run, watchdog disabled beforehand so the restore shows
        apb(1'b1, 12'h000, 8'ha8, 8'h00);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check(to_flag, 1'b0);
        check(pcz, 1'b1);
        check(pinit, 1'b1);
        rst_b <= 1'b1;
        apb(1'b0, 12'h000, 8'h00, 8'h53);
        check(pinit, 1'b0);
        give_verdict();
    end
endmodule
